//--- rtl/dcff_defines.svh
// constants for the dual-clock fifo flag control block
`ifndef DCFF_DEFINES_SVH
`define DCFF_DEFINES_SVH

// default geometry: 2^16 words of 36 bits
`define DCFF_ADDR_W 16
`define DCFF_DATA_W 36

// register byte offsets
`define DCFF_REG_EMPTY_OFS 4'h0
`define DCFF_REG_FULL_OFS 4'h4
`define DCFF_REG_STATUS 4'h8
`define DCFF_REG_COUNT 4'hC

// status register bit positions
`define DCFF_ST_EMPTY 0
`define DCFF_ST_FULL 1
`define DCFF_ST_OUT_RDY 2
`define DCFF_ST_IN_RDY 3
`define DCFF_ST_AEMPTY 4
`define DCFF_ST_AFULL 5
`define DCFF_ST_HALF 6
`define DCFF_ST_FALL_THROUGH_MODE 7
`define DCFF_ST_SERIAL 8
`define DCFF_ST_SYNC_FLAGS 9

// default offsets chosen at reset
`define DCFF_OFS_16383 16'h3FFF
`define DCFF_OFS_8191 16'h1FFF
`define DCFF_OFS_4095 16'h0FFF
`define DCFF_OFS_2047 16'h07FF
`define DCFF_OFS_1023 16'h03FF
`define DCFF_OFS_511 16'h01FF
`define DCFF_OFS_255 16'h00FF
`define DCFF_OFS_127 16'h007F

// timing counts in clock cycles / link clock edges
`define DCFF_STRAP_WAIT 2'h3
`define DCFF_FT_LAST_EDGE 2'h2

// reset values of the flag outputs (zero words held)
`define DCFF_RST_EMPTY_N 1'h0
`define DCFF_RST_FULL_N 1'h1
`define DCFF_RST_OUT_RDY_N 1'h1
`define DCFF_RST_IN_RDY_N 1'h0
`define DCFF_RST_AEMPTY_N 1'h0
`define DCFF_RST_AFULL_N 1'h1
`define DCFF_RST_HALF_N 1'h1

`endif

//--- rtl/dcff_pkg.sv
// types shared by the dual-clock fifo flag control block
package dcff_pkg;
	typedef enum logic {DCFF_STANDARD, DCFF_FALL_THROUGH} dcff_mode_t;
	typedef enum logic {DCFF_PARALLEL, DCFF_SERIAL} dcff_load_t;
endpackage : dcff_pkg

//--- rtl/dcff_sync.sv
// two-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
module dcff_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// bundle
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	// meta_reg feeds only q; nothing else may look at it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : dcff_sync

//--- rtl/dcff_top.sv
// dual-clock fifo with flag control, offsets and avalon register port
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`include "dcff_defines.svh"
`timescale 1ns/1ps
module dcff_top
	import dcff_pkg::*;
#(
	parameter int ADDR_W = `DCFF_ADDR_W,
	parameter int DATA_W = `DCFF_DATA_W
) (
	// system
	input wire logic CLK,
	input wire logic NRST,
	// avalon-mm slave
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// write side
	input wire logic WCLK,
	input wire logic WEN_N,
	input wire logic [DATA_W-1:0] DATA_IN,
	// read side
	input wire logic RCLK,
	input wire logic REN_N,
	output logic [DATA_W-1:0] DATA_OUT,
	// reset straps and offset access
	input wire logic MODE_SEL_SERIAL_IN,
	input wire logic OFFSET_LOAD_N,
	input wire logic OFFSET_SELECT_1,
	input wire logic OFFSET_SELECT_0,
	input wire logic FLAG_TIMING_SELECT,
	// flags
	output logic EMPTY_FLAG_N,
	output logic FULL_FLAG_N,
	output logic OUTPUT_READY_N,
	output logic INPUT_READY_N,
	output logic ALMOST_EMPTY_N,
	output logic ALMOST_FULL_N,
	output logic HALF_FULL_N
);
	localparam int HW = ADDR_W + 2;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int SW = DATA_W + 9;
	localparam logic [ADDR_W:0] CNT_FULL = (ADDR_W+1)'(DEPTH);

	function automatic logic [15:0] default_offset(input logic ld,
		input logic s1, input logic s0);
		case ({ld, s1, s0})
			3'h2: default_offset = `DCFF_OFS_16383;
			3'h1: default_offset = `DCFF_OFS_8191;
			3'h3: default_offset = `DCFF_OFS_4095;
			3'h0: default_offset = `DCFF_OFS_127;
			3'h6: default_offset = `DCFF_OFS_2047;
			3'h4: default_offset = `DCFF_OFS_1023;
			3'h5: default_offset = `DCFF_OFS_511;
			default: default_offset = `DCFF_OFS_255;
		endcase
	endfunction : default_offset
	logic [SW-1:0] pins_s;
	logic wclk_s, rclk_s, wen_s, ren_s, mode_s, ld_s, sel1_s, sel0_s;
	logic pfm_s;
	logic [DATA_W-1:0] din_s;
	dcff_sync #(.WIDTH(SW)) u_sync (
		.clk(CLK),
		.nrst(NRST),
		.d({WCLK, RCLK, WEN_N, REN_N, MODE_SEL_SERIAL_IN, OFFSET_LOAD_N,
			OFFSET_SELECT_1, OFFSET_SELECT_0, FLAG_TIMING_SELECT, DATA_IN}),
		.q(pins_s)
	);
	assign {wclk_s, rclk_s, wen_s, ren_s, mode_s, ld_s, sel1_s, sel0_s,
		pfm_s, din_s} = pins_s;

	// straps are caught once the synchroniser holds real pin levels
	logic [1:0] strap_cnt_reg;
	logic strap_done_reg;
	dcff_mode_t mode_reg;
	dcff_load_t load_reg;
	logic sync_flags_reg;
	logic fall_through_mode;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			strap_cnt_reg <= 2'h0;
			strap_done_reg <= 1'b0;
			mode_reg <= DCFF_STANDARD;
			load_reg <= DCFF_PARALLEL;
			sync_flags_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			strap_cnt_reg <= strap_cnt_reg + 2'h1;
			if (strap_cnt_reg == `DCFF_STRAP_WAIT) begin
				strap_done_reg <= 1'b1;
				mode_reg <= mode_s ? DCFF_FALL_THROUGH : DCFF_STANDARD;
				load_reg <= ld_s ? DCFF_SERIAL : DCFF_PARALLEL;
				sync_flags_reg <= pfm_s;
			end
		end
	end
	assign fall_through_mode = (mode_reg == DCFF_FALL_THROUGH);

	// link clock edges, ignored until the straps are taken
	logic wclk_d_reg, rclk_d_reg;
	logic wr_edge, rd_edge;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			wclk_d_reg <= 1'b0;
			rclk_d_reg <= 1'b0;
		end else begin
			wclk_d_reg <= wclk_s;
			rclk_d_reg <= rclk_s;
		end
	end
	assign wr_edge = wclk_s & ~wclk_d_reg & strap_done_reg;
	assign rd_edge = rclk_s & ~rclk_d_reg & strap_done_reg;

	// storage and occupancy
	logic [DATA_W-1:0] mem [DEPTH];
	logic [ADDR_W-1:0] wptr_reg, rptr_reg;
	logic [ADDR_W:0] count_reg;
	logic out_valid_reg;
	logic [1:0] ft_cnt_reg;
	logic mem_empty, mem_full, wr_mem, rd_ack, load_out, rd_mem;
	assign mem_empty = (count_reg == '0);
	assign mem_full = (count_reg == CNT_FULL);
	assign wr_mem = wr_edge & ~wen_s & ld_s & ~mem_full;
	// a read never runs ahead of the data: empty fifo ignores read enable
	assign rd_ack = rd_edge & ~ren_s & ld_s &
		(fall_through_mode ? out_valid_reg : ~mem_empty);
	assign load_out = fall_through_mode & ~mem_empty & ((rd_ack) | (~out_valid_reg &
		rd_edge & ft_cnt_reg == `DCFF_FT_LAST_EDGE));
	assign rd_mem = fall_through_mode ? load_out : rd_ack;
	always_ff @(posedge CLK) begin
		if (wr_mem)
			mem[wptr_reg] <= din_s;
	end
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (wr_mem)
				wptr_reg <= wptr_reg + 1'b1;
			if (rd_mem)
				rptr_reg <= rptr_reg + 1'b1;
			if (wr_mem && !rd_mem)
				count_reg <= count_reg + 1'b1;
			else if (rd_mem && !wr_mem)
				count_reg <= count_reg - 1'b1;
		end
	end

	// fall-through output register; the edge count stands for the
	// three register stages in front of the output-ready flag
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			out_valid_reg <= 1'b0;
			ft_cnt_reg <= 2'h0;
		end else begin
			if (load_out)
				out_valid_reg <= 1'b1;
			else if (rd_ack && fall_through_mode)
				out_valid_reg <= 1'b0;
			if (out_valid_reg || mem_empty || load_out)
				ft_cnt_reg <= 2'h0;
			else if (rd_edge)
				ft_cnt_reg <= ft_cnt_reg + 2'h1;
		end
	end

	// offsets: bus, or pins in parallel load mode, may write them once the straps are taken
	logic [ADDR_W-1:0] empty_ofs_reg, full_ofs_reg;
	logic pin_wsel_reg, pin_rsel_reg;
	logic bus_wr_en, pin_ofs_wr, pin_ofs_rd;
	assign pin_ofs_wr = wr_edge & ~wen_s & ~ld_s &
		(load_reg == DCFF_PARALLEL);
	assign pin_ofs_rd = rd_edge & ~ren_s & ~ld_s;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			empty_ofs_reg <= '0;
			full_ofs_reg <= '0;
			pin_wsel_reg <= 1'b0;
		end else if (strap_done_reg) begin
			if (bus_wr_en && AVS_ADDRESS == `DCFF_REG_EMPTY_OFS)
				empty_ofs_reg <= AVS_WRITEDATA[ADDR_W-1:0];
			else if (pin_ofs_wr && !pin_wsel_reg)
				empty_ofs_reg <= din_s[ADDR_W-1:0];
			if (bus_wr_en && AVS_ADDRESS == `DCFF_REG_FULL_OFS)
				full_ofs_reg <= AVS_WRITEDATA[ADDR_W-1:0];
			else if (pin_ofs_wr && pin_wsel_reg)
				full_ofs_reg <= din_s[ADDR_W-1:0];
			if (pin_ofs_wr)
				pin_wsel_reg <= ~pin_wsel_reg;
		end else if (strap_cnt_reg == `DCFF_STRAP_WAIT) begin
			empty_ofs_reg <= ADDR_W'(default_offset(ld_s, sel1_s,
				sel0_s));
			full_ofs_reg <= ADDR_W'(default_offset(ld_s, sel1_s,
				sel0_s));
		end
	end

	// data output: memory word, or offset readback while load is low
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			DATA_OUT <= '0;
			pin_rsel_reg <= 1'b0;
		end else begin
			if (rd_mem)
				DATA_OUT <= mem[rptr_reg];
			else if (pin_ofs_rd)
				DATA_OUT <= DATA_W'(pin_rsel_reg ? full_ofs_reg
					: empty_ofs_reg);
			if (pin_ofs_rd)
				pin_rsel_reg <= ~pin_rsel_reg;
		end
	end

	// thresholds: fall-through counts the output register as one more
	logic [HW-1:0] held, extra, pae_thr, hf_thr, full_thr, paf_thr;
	assign extra = HW'(fall_through_mode);
	assign held = HW'(count_reg) + HW'(fall_through_mode & out_valid_reg);
	assign pae_thr = HW'(empty_ofs_reg) + HW'(1) + extra;
	assign hf_thr = HW'(DEPTH / 2) + HW'(1) + extra;
	assign full_thr = HW'(DEPTH) + extra;
	assign paf_thr = full_thr - HW'(full_ofs_reg);

	// empty/full pass two stages, each on its own link clock
	logic empty_s1_reg, full_s1_reg;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			empty_s1_reg <= `DCFF_RST_EMPTY_N;
			EMPTY_FLAG_N <= `DCFF_RST_EMPTY_N;
			OUTPUT_READY_N <= `DCFF_RST_OUT_RDY_N;
		end else begin
			if (rd_edge && !fall_through_mode) begin
				empty_s1_reg <= ~mem_empty;
				EMPTY_FLAG_N <= empty_s1_reg;
			end
			OUTPUT_READY_N <= ~(fall_through_mode & out_valid_reg);
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			full_s1_reg <= `DCFF_RST_FULL_N;
			FULL_FLAG_N <= `DCFF_RST_FULL_N;
			INPUT_READY_N <= `DCFF_RST_IN_RDY_N;
		end else if (wr_edge) begin
			full_s1_reg <= ~(held == full_thr);
			FULL_FLAG_N <= fall_through_mode ? `DCFF_RST_FULL_N : full_s1_reg;
			INPUT_READY_N <= fall_through_mode ? ~full_s1_reg
				: `DCFF_RST_IN_RDY_N;
		end
	end

	// synchronous timing holds almost-empty and almost-full to their own clocks; half-full updates every cycle
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ALMOST_EMPTY_N <= `DCFF_RST_AEMPTY_N;
			ALMOST_FULL_N <= `DCFF_RST_AFULL_N;
			HALF_FULL_N <= `DCFF_RST_HALF_N;
		end else if (strap_done_reg) begin
			if (rd_edge || !sync_flags_reg)
				ALMOST_EMPTY_N <= (held >= pae_thr);
			if (wr_edge || !sync_flags_reg)
				ALMOST_FULL_N <= ~(held >= paf_thr);
			HALF_FULL_N <= ~(held >= hf_thr);
		end
	end

	// avalon slave: one wait cycle, then the answer
	logic [31:0] status_word;
	assign bus_wr_en = AVS_WRITE & ~AVS_WAITREQUEST;
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`DCFF_ST_EMPTY] = EMPTY_FLAG_N;
		status_word[`DCFF_ST_FULL] = FULL_FLAG_N;
		status_word[`DCFF_ST_OUT_RDY] = OUTPUT_READY_N;
		status_word[`DCFF_ST_IN_RDY] = INPUT_READY_N;
		status_word[`DCFF_ST_AEMPTY] = ALMOST_EMPTY_N;
		status_word[`DCFF_ST_AFULL] = ALMOST_FULL_N;
		status_word[`DCFF_ST_HALF] = HALF_FULL_N;
		status_word[`DCFF_ST_FALL_THROUGH_MODE] = fall_through_mode;
		status_word[`DCFF_ST_SERIAL] = (load_reg == DCFF_SERIAL);
		status_word[`DCFF_ST_SYNC_FLAGS] = sync_flags_reg;
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h0000_0000;
		end else if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
			AVS_WAITREQUEST <= 1'b0;
			case (AVS_ADDRESS)
				`DCFF_REG_EMPTY_OFS: AVS_READDATA <= 32'(empty_ofs_reg);
				`DCFF_REG_FULL_OFS: AVS_READDATA <= 32'(full_ofs_reg);
				`DCFF_REG_STATUS: AVS_READDATA <= status_word;
				`DCFF_REG_COUNT: AVS_READDATA <= 32'(held);
				default: AVS_READDATA <= 32'h0000_0000;
			endcase
		end else begin
			AVS_WAITREQUEST <= 1'b1;
		end
	end

	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	mode_latch_a: assert property ($rose(strap_done_reg) |->
		fall_through_mode == $past(mode_s)) else $error("mode strap not latched");
	default_ofs_a: assert property ($rose(strap_done_reg) |->
		empty_ofs_reg == ADDR_W'(default_offset($past(ld_s),
		$past(sel1_s), $past(sel0_s))) && full_ofs_reg == empty_ofs_reg)
		else $error("default offset wrong");
	no_overfill_a: assert property ((mem_full && !rd_mem) |=>
		mem_full) else $error("write accepted while full");
	no_underrun_a: assert property ((mem_empty && !fall_through_mode) |->
		!rd_mem) else $error("read accepted while empty");
	write_count_a: assert property ((wr_mem && !rd_mem) |=>
		count_reg == $past(count_reg) + 1'b1)
		else $error("write did not add a word");
	fall_edge_a: assert property ((fall_through_mode && !out_valid_reg && load_out)
		|-> rd_edge && ft_cnt_reg == 2'h2 && $past(ft_cnt_reg) == 2'h2)
		else $error("first word fell through early");
	drain_ready_a: assert property ((fall_through_mode && out_valid_reg && rd_ack
		&& mem_empty && !wr_mem) |=> ##1 OUTPUT_READY_N)
		else $error("output ready not dropped");
	half_flag_a: assert property (strap_done_reg ##1 strap_done_reg
		|-> HALF_FULL_N == !($past(held) >= $past(hf_thr)))
		else $error("half-full flag wrong");
	empty_stage_a: assert property ((!fall_through_mode && rd_edge && mem_empty
		&& !empty_s1_reg) |=> !empty_s1_reg && !EMPTY_FLAG_N)
		else $error("empty flag missed two stages");

	fill_c: cover property (mem_full && !FULL_FLAG_N);
	fall_c: cover property (fall_through_mode && $rose(out_valid_reg));
	readback_c: cover property (pin_ofs_rd);
	bus_wr_c: cover property (bus_wr_en);
endmodule : dcff_top

//--- tb/dcff_link_model.sv
// writer and reader on the far side of the two link ports
`timescale 1ns/1ps
module dcff_link_model #(
	parameter int DATA_W = 36
) (
	// pacing clock
	input wire logic clk,
	// link pins
	output logic wclk,
	output logic rclk,
	output logic wen_n,
	output logic [DATA_W-1:0] data_in,
	output logic ren_n
);
	initial begin
		wclk = 1'b0;
		rclk = 1'b0;
		wen_n = 1'b1;
		ren_n = 1'b1;
		data_in = '0;
	end
	// link clocks run free, offset so no edge lines up with clk
	initial #13 forever #40 wclk = ~wclk;
	initial #31 forever #40 rclk = ~rclk;

	// enable is held over exactly one rising link edge
	task put_word(input logic [DATA_W-1:0] d, input int gap);
		repeat (gap) @(posedge wclk);
		@(negedge wclk);
		@(posedge clk);
		wen_n <= 1'b0;
		data_in <= d;
		@(negedge wclk);
		@(posedge clk);
		wen_n <= 1'b1;
		// released data inverted so stale values never look valid
		data_in <= ~d;
	endtask : put_word

	task take_word(input int gap);
		repeat (gap) @(posedge rclk);
		@(negedge rclk);
		@(posedge clk);
		ren_n <= 1'b0;
		@(negedge rclk);
		@(posedge clk);
		ren_n <= 1'b1;
	endtask : take_word
endmodule : dcff_link_model

//--- tb/tb_top.sv
// self-checking bench for the dual-clock fifo flag control block
`timescale 1ns/1ps
module tb_top;
	localparam int AW = 4;
	localparam int DEPTH = 16;
	localparam int N_OFS = 2;
	localparam int M_OFS = 3;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic wclk, wen_n, rclk, ren_n;
	logic [35:0] data_in, data_out, wd;
	logic mode_sel = 1'b0;
	logic load_n = 1'b0;
	logic [1:0] sel = 2'h2;
	logic timing_sel = 1'b0;
	logic ef_n, ff_n, or_n, ir_n, ae_n, af_n, hf_n;
	logic [31:0] rd;
	logic [35:0] q[$];
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;
	int cnt = 0;
	int mode = 0;
	integer seed = 32'hDB21F9CA;

	always #5 clk = ~clk;

	dcff_top #(.ADDR_W(AW), .DATA_W(36)) i_dut (
		.CLK(clk), .NRST(nrst),
		.AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
		.AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
		.WCLK(wclk), .WEN_N(wen_n), .DATA_IN(data_in),
		.RCLK(rclk), .REN_N(ren_n), .DATA_OUT(data_out),
		.MODE_SEL_SERIAL_IN(mode_sel), .OFFSET_LOAD_N(load_n),
		.OFFSET_SELECT_1(sel[1]), .OFFSET_SELECT_0(sel[0]),
		.FLAG_TIMING_SELECT(timing_sel),
		.EMPTY_FLAG_N(ef_n), .FULL_FLAG_N(ff_n), .OUTPUT_READY_N(or_n),
		.INPUT_READY_N(ir_n), .ALMOST_EMPTY_N(ae_n),
		.ALMOST_FULL_N(af_n), .HALF_FULL_N(hf_n));

	dcff_link_model #(.DATA_W(36)) i_link (.clk(clk), .wclk(wclk),
		.rclk(rclk), .wen_n(wen_n), .data_in(data_in), .ren_n(ren_n));

	task report_and_stop;
		if (bad_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			report_and_stop();
		end
	end

	task chk(input logic [35:0] got, input logic [35:0] exp);
		checked++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask : chk

	task bus_rd(input logic [3:0] a);
		@(posedge clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
	endtask : bus_rd

	task bus_wr(input logic [3:0] a, input int d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= 32'(d);
		avs_write <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask : bus_wr

	// flags have no handshake; wait out the sync stages on both links
	task chk_flags;
		repeat (80) @(posedge clk);
		chk(36'(ff_n), 36'(mode == 1 || cnt != DEPTH));
		chk(36'(or_n), 36'(mode == 0 || cnt == 0));
		chk(36'(ir_n), 36'(mode == 1 && cnt == DEPTH + 1));
		chk(36'(ae_n), 36'(cnt >= N_OFS + 1 + mode));
		chk(36'(af_n), 36'(cnt < DEPTH + mode - M_OFS));
		chk(36'(hf_n), 36'(cnt < DEPTH / 2 + 1 + mode));
		if (mode == 0)
			chk(36'(ef_n), 36'(cnt != 0));
		bus_rd(4'hC);
		chk(36'(rd), 36'(cnt));
	endtask : chk_flags

	task run_mode(input int m);
		@(posedge clk);
		mode = m;
		nrst <= 1'b0;
		mode_sel <= m[0];
		load_n <= m[0];
		timing_sel <= m[0];
		sel <= m[0] ? 2'h3 : 2'h1;
		cnt = 0;
		q.delete();
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (10) @(posedge clk);
		load_n <= 1'b1;
		bus_rd(4'h8);
		chk(36'(rd[9:7]), 36'({3{m[0]}}));
		chk_flags();
		bus_wr(4'h0, N_OFS);
		bus_wr(4'h4, M_OFS);
		bus_rd(4'h0);
		chk(36'(rd), 36'(N_OFS));
		bus_rd(4'h4);
		chk(36'(rd), 36'(M_OFS));
		bus_rd(4'h2);
		chk(36'(rd), 36'h0);
		// offsets come back on the data port, n first, while load is low
		load_n <= 1'b0;
		i_link.take_word(0);
		chk(data_out, 36'(N_OFS));
		i_link.take_word(0);
		chk(data_out, 36'(M_OFS));
		load_n <= 1'b1;
		// one write past full must be refused
		for (int i = 0; i <= DEPTH + m; i++) begin
			wd = 36'({$random(seed), $random(seed)});
			i_link.put_word(wd, i % 3);
			if (cnt < DEPTH + m) begin
				q.push_back(wd);
				cnt++;
			end
			chk_flags();
			if (m == 1)
				chk(data_out, q[0]);
		end
		// one read past empty must be ignored
		for (int i = 0; i <= DEPTH + m; i++) begin
			i_link.take_word(i % 2);
			if (cnt > 0) begin
				wd = q.pop_front();
				cnt--;
				if (m == 0)
					chk(data_out, wd);
			end
			else if (m == 0)
				chk(data_out, wd);
			chk_flags();
			if (m == 1 && cnt > 0)
				chk(data_out, q[0]);
		end
	endtask : run_mode

	initial begin
		run_mode(0);
		run_mode(1);
		report_and_stop();
	end
endmodule : tb_top
